// file: logic/signal_measure_timer_control.v
// control, status and source selection of the measurement timer
`timescale 1ns/1ps
`include "signal_measure_timer_regs.vh"

// Overview of operation
// - enable clear resets state, drops clock request
// - halt bit: counter holds at limit, match
// - no halt: counter wraps to zero, match
// - window polarity picks level and edge
// - signal polarity picks level and edge
// - clock polarity picks counting edge
// - prescaler divides by 1, 2, 4, 8
// - go bit allows counting and acquisition
// - repeat selects continuous or single acquisition
// - four-bit mode field, reserved codes idle
// - period capture update request, self clearing
// - width capture update request, self clearing
// - counter clear request, reads zero after
// - counting status shows counter incrementing
// - window status shows window open
// - acquisition status shows acquisition running
// - three-bit counting clock source select
// - five-bit signal source select, reserved codes
// - five-bit window source select, reserved codes
// - 24-bit period limit sets wrap point
module signal_measure_timer_control
#(
    parameter CNT_W = 24                // counter width
)
(
    input  wire                  core_clk,    // system clock
    input  wire                  rst_b,       // async reset
    input  wire [`MT_ADDR_W-1:0] regAddr,     // register address
    input  wire [7:0]            regWrData,   // write data
    input  wire                  regWr,       // write strobe
    input  wire                  regRd,       // read strobe
    output reg  [7:0]            regRdData,   // read data
    input  wire [7:1]            clkSrcIn,    // clock sources 1..7
    input  wire                  sigPin,      // signal pin
    input  wire [21:1]           sigSrcIn,    // signal sources
    input  wire                  winPin,      // window pin
    input  wire [23:1]           winSrcIn,    // window sources
    output reg                   clockReq,    // clock request
    output reg                   periodMatch, // match pulse
    output reg                   windowOpen   // window level
);

    reg  [7:0]       ctrlA_reg;
    reg  [7:0]       ctrlB_reg;
    reg  [2:0]       clkSel_reg;
    reg  [4:0]       sigSel_reg;
    reg  [4:0]       winSel_reg;
    reg              cprReq_reg;
    reg              cpwReq_reg;
    reg              clrReq_reg;
    reg              counting_reg;
    reg              acq_reg;
    reg  [CNT_W-1:0] period_reg;
    reg  [CNT_W-1:0] count_reg;
    reg  [CNT_W-1:0] cpr_reg;
    reg  [CNT_W-1:0] cpw_reg;
    reg  [1:0]       instrDiv_reg;
    reg  [2:0]       syncA_reg;
    reg  [2:0]       syncB_reg;
    reg  [2:0]       syncC_reg;
    reg  [2:0]       preCnt_reg;
    reg              matchPend_reg;
    reg  [7:0]       rdData_next;
    reg              clkRaw;
    reg              sigRaw;
    reg              winRaw;
    reg              gate;
    reg              edgeMode;
    reg              modeValid;
    reg  [CNT_W-1:0] count_next;

    wire       enable    = ctrlA_reg[`MT_A_ENABLE];
    wire       halt      = ctrlA_reg[`MT_A_HALT];
    wire       window_polarity      = ctrlA_reg[`MT_A_WINDOW_POLARITY];
    wire       signal_polarity      = ctrlA_reg[`MT_A_SIGNAL_POLARITY];
    wire       count_clock_polarity      = ctrlA_reg[`MT_A_COUNT_CLOCK_POLARITY];
    wire [1:0] prescale  = ctrlA_reg[1:0];
    wire       go        = ctrlB_reg[`MT_B_GO];
    wire       repeatAcq = ctrlB_reg[`MT_B_REPEAT];
    wire [3:0] mode      = ctrlB_reg[3:0];

    wire wrA   = regWr && (regAddr == `MT_OFS_CTRL_A);
    wire wrB   = regWr && (regAddr == `MT_OFS_CTRL_B);
    wire wrSt  = regWr && (regAddr == `MT_OFS_STATUS);
    wire wrClk = regWr && (regAddr == `MT_OFS_CLK_SEL);
    wire wrSig = regWr && (regAddr == `MT_OFS_SIG_SEL);
    wire wrWin = regWr && (regAddr == `MT_OFS_WIN_SEL);
    wire wrPl  = regWr && (regAddr == `MT_OFS_PER_L);
    wire wrPh  = regWr && (regAddr == `MT_OFS_PER_H);
    wire wrPu  = regWr && (regAddr == `MT_OFS_PER_U);

    // source multiplexers; reserved codes feed a constant low
    always @*
    begin
        if (clkSel_reg == `MT_CLOCK_SOURCE_FIELD_INSTR)
            clkRaw = instrDiv_reg[1];
        else
            clkRaw = clkSrcIn[clkSel_reg];
        if (sigSel_reg == 5'h00)
            sigRaw = sigPin;
        else if (sigSel_reg > `MT_SSEL_LAST)
            sigRaw = 1'b0;
        else
            sigRaw = sigSrcIn[sigSel_reg];
        if (winSel_reg == 5'h00)
            winRaw = winPin;
        else if (winSel_reg == `MT_WINDOW_SOURCE_FIELD_HOLE)
            winRaw = 1'b0;
        else if (winSel_reg > `MT_WINDOW_SOURCE_FIELD_LAST)
            winRaw = 1'b0;
        else
            winRaw = winSrcIn[winSel_reg];
    end

    // stage B and C only; stage A feeds stage B alone
    wire clkLvl  = syncB_reg[0] ^ count_clock_polarity;
    wire clkPrev = syncC_reg[0] ^ count_clock_polarity;
    wire sigLvl  = syncB_reg[1] ^ signal_polarity;
    wire sigPrev = syncC_reg[1] ^ signal_polarity;
    wire winLvl  = syncB_reg[2] ^ window_polarity;
    wire winPrev = syncC_reg[2] ^ window_polarity;
    wire sigEdge = sigLvl & ~sigPrev;
    wire winEdge = winLvl & ~winPrev;

    // the system clock source gives one edge per core cycle
    wire clkEdge = (clkSel_reg == `MT_CLOCK_SOURCE_FIELD_SYSTEM) ? 1'b1
                   : (clkLvl & ~clkPrev);

    wire [2:0] preMask = (3'h1 << prescale) - 3'h1;
    wire       preTick = clkEdge && (preCnt_reg == preMask);

    // mode decides what gates the count and what clocks it
    always @*
    begin
        gate      = 1'b1;
        edgeMode  = 1'b0;
        modeValid = 1'b1;
        case (mode)
            `MT_MODE_TIMER:    gate = 1'b1;
            `MT_MODE_GTIMER:   gate = sigLvl;
            `MT_MODE_PERDUTY:  gate = 1'b1;
            `MT_MODE_HILO:     gate = 1'b1;
            `MT_MODE_WINDOW:   gate = winLvl;
            `MT_MODE_GWINDOW:  gate = winLvl & sigLvl;
            `MT_MODE_TOF:      gate = winLvl;
            `MT_MODE_CAPTURE:  gate = 1'b1;
            `MT_MODE_COUNTER:  edgeMode = 1'b1;
            `MT_MODE_GCOUNTER:
            begin
                edgeMode = 1'b1;
                gate     = winLvl;
            end
            `MT_MODE_WCOUNTER:
            begin
                edgeMode = 1'b1;
                gate     = winLvl;
            end
            default:
            begin
                modeValid = 1'b0;
                gate      = 1'b0;
            end
        endcase
    end

    wire running = enable && go && modeValid && gate;
    wire step    = running && (edgeMode ? sigEdge : preTick);
    wire atLimit = (count_reg == period_reg);

    // a match in single mode ends the acquisition
    wire singleEnd = step && atLimit && !repeatAcq;

    always @*
    begin
        count_next = count_reg;
        // disable and the clear request win over any step
        if (!enable || clrReq_reg)
            count_next = {CNT_W{1'b0}};
        else if (step && atLimit && halt)
            count_next = period_reg;
        else if (step && atLimit)
            count_next = {CNT_W{1'b0}};
        else if (step)
            count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end

    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrlA_reg  <= `MT_RST_BYTE;
            ctrlB_reg  <= `MT_RST_BYTE;
            clkSel_reg <= 3'h0;
            sigSel_reg <= 5'h00;
            winSel_reg <= 5'h00;
            period_reg <= `MT_RST_PERIOD;
        end
        else
        begin
            if (wrA)
                ctrlA_reg <= {regWrData[7], 1'b0, regWrData[5:0]};
            if (wrB)
                ctrlB_reg <= {regWrData[7:6], 2'h0, regWrData[3:0]};
            else if (singleEnd)
                ctrlB_reg[`MT_B_GO] <= 1'b0;
            if (wrClk)
                clkSel_reg <= regWrData[2:0];
            if (wrSig)
                sigSel_reg <= regWrData[4:0];
            if (wrWin)
                winSel_reg <= regWrData[4:0];
            if (wrPl)
                period_reg[7:0] <= regWrData;
            if (wrPh)
                period_reg[15:8] <= regWrData;
            if (wrPu)
                period_reg[23:16] <= regWrData;
        end
    end

    // requests: a new write of one wins over the hardware clear
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cprReq_reg <= 1'b0;
            cpwReq_reg <= 1'b0;
            clrReq_reg <= 1'b0;
            cpr_reg    <= {CNT_W{1'b0}};
            cpw_reg    <= {CNT_W{1'b0}};
        end
        else
        begin
            if (wrSt && regWrData[`MT_S_PERIOD_CAPTURE_UPDATE_REQUEST])
                cprReq_reg <= 1'b1;
            else if (cprReq_reg)
                cprReq_reg <= 1'b0;
            if (wrSt && regWrData[`MT_S_WIDTH_CAPTURE_UPDATE_REQUEST])
                cpwReq_reg <= 1'b1;
            else if (cpwReq_reg)
                cpwReq_reg <= 1'b0;
            if (wrSt && regWrData[`MT_S_CLEAR])
                clrReq_reg <= 1'b1;
            else if (clrReq_reg)
                clrReq_reg <= 1'b0;
            if (cprReq_reg)
                cpr_reg <= count_reg;
            if (cpwReq_reg)
                cpw_reg <= count_reg;
        end
    end

    // measurement state; all of it collapses while disabled
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            instrDiv_reg  <= 2'h0;
            syncA_reg     <= 3'h0;
            syncB_reg     <= 3'h0;
            syncC_reg     <= 3'h0;
            preCnt_reg    <= 3'h0;
            count_reg     <= {CNT_W{1'b0}};
            matchPend_reg <= 1'b0;
            periodMatch   <= 1'b0;
            counting_reg  <= 1'b0;
            acq_reg       <= 1'b0;
            clockReq      <= 1'b0;
            windowOpen    <= 1'b0;
        end
        else if (!enable)
        begin
            instrDiv_reg  <= 2'h0;
            syncA_reg     <= 3'h0;
            syncB_reg     <= 3'h0;
            syncC_reg     <= 3'h0;
            preCnt_reg    <= 3'h0;
            count_reg     <= {CNT_W{1'b0}};
            matchPend_reg <= 1'b0;
            periodMatch   <= 1'b0;
            counting_reg  <= 1'b0;
            acq_reg       <= 1'b0;
            clockReq      <= 1'b0;
            windowOpen    <= 1'b0;
        end
        else
        begin
            instrDiv_reg <= instrDiv_reg + 2'h1;
            syncA_reg    <= {winRaw, sigRaw, clkRaw};
            syncB_reg    <= syncA_reg;
            syncC_reg    <= syncB_reg;
            if (!running || preTick)
                preCnt_reg <= 3'h0;
            else if (clkEdge)
                preCnt_reg <= preCnt_reg + 3'h1;
            count_reg <= count_next;
            // in repeat mode, match is signalled on the counting clock after equality
            if (step && atLimit)
                matchPend_reg <= 1'b1;
            else if (step || !running)
                matchPend_reg <= 1'b0;
            // single mode drops go at the match step, so signal it there
            periodMatch  <= (matchPend_reg && step)
                            || singleEnd;
            counting_reg <= step;
            // reserved modes never count, so they never show acquisition
            acq_reg      <= go && modeValid;
            // clock sources are requested only while enabled
            clockReq     <= 1'b1;
            windowOpen   <= winLvl;
        end
    end

    // register read mux; unmapped addresses read zero
    always @*
    begin
        rdData_next = 8'h00;
        if (regAddr == `MT_OFS_CTRL_A)
            rdData_next = ctrlA_reg;
        else if (regAddr == `MT_OFS_CTRL_B)
            rdData_next = ctrlB_reg;
        else if (regAddr == `MT_OFS_STATUS)
            rdData_next = {cprReq_reg, cpwReq_reg, 1'b0, clrReq_reg,
                           1'b0, counting_reg, windowOpen, acq_reg};
        else if (regAddr == `MT_OFS_CLK_SEL)
            rdData_next = {5'h00, clkSel_reg};
        else if (regAddr == `MT_OFS_SIG_SEL)
            rdData_next = {3'h0, sigSel_reg};
        else if (regAddr == `MT_OFS_WIN_SEL)
            rdData_next = {3'h0, winSel_reg};
        else if (regAddr == `MT_OFS_PER_L)
            rdData_next = period_reg[7:0];
        else if (regAddr == `MT_OFS_PER_H)
            rdData_next = period_reg[15:8];
        else if (regAddr == `MT_OFS_PER_U)
            rdData_next = period_reg[23:16];
        else if (regAddr == `MT_OFS_CNT_L)
            rdData_next = count_reg[7:0];
        else if (regAddr == `MT_OFS_CNT_H)
            rdData_next = count_reg[15:8];
        else if (regAddr == `MT_OFS_CNT_U)
            rdData_next = count_reg[23:16];
        else if (regAddr == `MT_OFS_CPR_L)
            rdData_next = cpr_reg[7:0];
        else if (regAddr == `MT_OFS_CPR_H)
            rdData_next = cpr_reg[15:8];
        else if (regAddr == `MT_OFS_CPR_U)
            rdData_next = cpr_reg[23:16];
        else if (regAddr == `MT_OFS_CPW_L)
            rdData_next = cpw_reg[7:0];
        else if (regAddr == `MT_OFS_CPW_H)
            rdData_next = cpw_reg[15:8];
        else if (regAddr == `MT_OFS_CPW_U)
            rdData_next = cpw_reg[23:16];
    end

    // read data stand only in the cycle after the strobe
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            regRdData <= 8'h00;
        else if (regRd)
            regRdData <= rdData_next;
        else
            regRdData <= 8'h00;
    end

endmodule

// file: common/signal_measure_timer_regs.vh
// register map, field positions, reset values and mode codes
`ifndef SIGNAL_MEASURE_TIMER_REGS_VH
`define SIGNAL_MEASURE_TIMER_REGS_VH

`define MT_ADDR_W          12
`define MT_OFS_CTRL_A      12'h0498
`define MT_OFS_CTRL_B      12'h0499
`define MT_OFS_STATUS      12'h049A
`define MT_OFS_CLK_SEL     12'h049B
`define MT_OFS_SIG_SEL     12'h049C
`define MT_OFS_WIN_SEL     12'h049D
`define MT_OFS_PER_L       12'h04A0
`define MT_OFS_PER_H       12'h04A1
`define MT_OFS_PER_U       12'h04A2
`define MT_OFS_CNT_L       12'h04A4
`define MT_OFS_CNT_H       12'h04A5
`define MT_OFS_CNT_U       12'h04A6
`define MT_OFS_CPR_L       12'h04A8
`define MT_OFS_CPR_H       12'h04A9
`define MT_OFS_CPR_U       12'h04AA
`define MT_OFS_CPW_L       12'h04AC
`define MT_OFS_CPW_H       12'h04AD
`define MT_OFS_CPW_U       12'h04AE

`define MT_A_ENABLE        7
`define MT_A_HALT          5
`define MT_A_WINDOW_POLARITY          4
`define MT_A_SIGNAL_POLARITY          3
`define MT_A_COUNT_CLOCK_POLARITY          2
`define MT_B_GO            7
`define MT_B_REPEAT        6
`define MT_S_PERIOD_CAPTURE_UPDATE_REQUEST         7
`define MT_S_WIDTH_CAPTURE_UPDATE_REQUEST         6
`define MT_S_CLEAR         4
`define MT_S_COUNTING      2
`define MT_S_WINDOW        1
`define MT_S_ACQ           0

`define MT_RST_BYTE        8'h00
`define MT_RST_PERIOD      24'hFF_FFFF

`define MT_MODE_TIMER      4'h0
`define MT_MODE_GTIMER     4'h1
`define MT_MODE_PERDUTY    4'h2
`define MT_MODE_HILO       4'h3
`define MT_MODE_WINDOW     4'h4
`define MT_MODE_GWINDOW    4'h5
`define MT_MODE_TOF        4'h6
`define MT_MODE_CAPTURE    4'h7
`define MT_MODE_COUNTER    4'h8
`define MT_MODE_GCOUNTER   4'h9
`define MT_MODE_WCOUNTER   4'hA

`define MT_CLOCK_SOURCE_FIELD_INSTR      3'h0
`define MT_CLOCK_SOURCE_FIELD_SYSTEM     3'h1
`define MT_SSEL_LAST       5'h15
`define MT_WINDOW_SOURCE_FIELD_HOLE       5'h16
`define MT_WINDOW_SOURCE_FIELD_LAST       5'h17

`endif

// file: verification/signal_measure_timer_control_sva.sv
// assertions on the timer control ports
`timescale 1ns/1ps
`include "signal_measure_timer_regs.vh"
module signal_measure_timer_control_chk
(
    input wire                  core_clk,    // clock
    input wire                  rst_b,       // reset
    input wire [`MT_ADDR_W-1:0] regAddr,     // address
    input wire [7:0]            regWrData,   // write data
    input wire                  regWr,       // write strobe
    input wire                  regRd,       // read strobe
    input wire [7:0]            regRdData,   // read data
    input wire                  clockReq,    // clock request
    input wire                  periodMatch, // match pulse
    input wire                  windowOpen   // window level
);
    reg                  lastWr_reg;
    reg [`MT_ADDR_W-1:0] lastAddr_reg;
    reg [7:0]            lastData_reg;
    wire                 back;
    wire                 rdSt;
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    always @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            lastWr_reg <= 1'b0;
        else
            lastWr_reg <= regWr;
    always @(posedge core_clk)
    begin
        lastAddr_reg <= regAddr;
        lastData_reg <= regWrData;
    end
    // read straight after a write to the same place
    assign back = regRd && lastWr_reg && regAddr == lastAddr_reg;
    assign rdSt = regRd && regAddr == `MT_OFS_STATUS;
    clk_req_on_a: assert property (
        lastWr_reg && lastAddr_reg == `MT_OFS_CTRL_A && lastData_reg[7]
        |=> clockReq) else $error("clock request not raised");
    clk_req_off_a: assert property (
        lastWr_reg && lastAddr_reg == `MT_OFS_CTRL_A && !lastData_reg[7]
        |=> !clockReq) else $error("clock request not dropped");
    match_when_on_a: assert property (periodMatch |-> clockReq)
        else $error("match while disabled");
    window_off_a: assert property (!clockReq |-> !windowOpen)
        else $error("window open while disabled");
    win_status_a: assert property (
        rdSt |=> regRdData[1] == $past(windowOpen))
        else $error("window status differs from window output");
    rd_idle_a: assert property (!regRd |=> regRdData == 8'h00)
        else $error("read data outside read cycle");
    ctrl_a_back_a: assert property (
        back && regAddr == `MT_OFS_CTRL_A |=>
        regRdData == ($past(lastData_reg) & 8'hBF))
        else $error("control A readback wrong");
    clk_sel_back_a: assert property (
        back && regAddr == `MT_OFS_CLK_SEL |=>
        regRdData == ($past(lastData_reg) & 8'h07))
        else $error("clock select readback wrong");
    sig_sel_back_a: assert property (
        back && regAddr == `MT_OFS_SIG_SEL |=>
        regRdData == ($past(lastData_reg) & 8'h1F))
        else $error("signal select readback wrong");
    req_clear_a: assert property (
        regWr && regAddr == `MT_OFS_STATUS && (regWrData & 8'hD0) != 8'h00
        ##1 !regWr ##1 rdSt |=> (regRdData & 8'hD0) == 8'h00)
        else $error("request bit not cleared");
    cover property (periodMatch);
    cover property ($rose(windowOpen));
    cover property (back);
endmodule
bind signal_measure_timer_control signal_measure_timer_control_chk i_chk
(
    .core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .clockReq(clockReq),
    .periodMatch(periodMatch), .windowOpen(windowOpen)
);

// file: verification/measure_source_model.sv
// signal, window and clock sources feeding the timer
`timescale 1ns/1ps
module measure_source_model
(
    input  wire        core_clk, // clock
    input  wire        rst_b,    // reset
    input  wire [4:0]  sigCode,  // source carrying sigLevel
    input  wire        sigLevel, // wanted signal level
    input  wire [4:0]  winCode,  // source carrying winLevel
    input  wire        winLevel, // wanted window level
    output wire [7:1]  clkSrcIn, // slow clocks
    output wire        sigPin,   // signal pin
    output wire [21:1] sigSrcIn, // signal sources
    output wire        winPin,   // window pin
    output wire [23:1] winSrcIn  // window sources
);
    reg [2:0] div_reg;
    always @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            div_reg <= 3'h0;
        else
            div_reg <= div_reg + 3'h1;
    // unselected signal and window sources show the inverse, so a wrong pick is seen; all seven clocks carry the same divided clock
    assign clkSrcIn = {7{div_reg[2]}};
    assign sigPin   = (sigCode == 5'h00) ? sigLevel : !sigLevel;
    assign sigSrcIn = {21{!sigLevel}} ^ (21'h1 << (sigCode - 5'h01));
    assign winPin   = (winCode == 5'h00) ? winLevel : !winLevel;
    assign winSrcIn = {23{!winLevel}} ^ (23'h1 << (winCode - 5'h01));
endmodule

// file: verification/signal_measure_timer_control_tb.sv
// self-checking bench for the timer control
`timescale 1ns/1ps
`include "signal_measure_timer_regs.vh"
module signal_measure_timer_control_tb;
    reg         core_clk = 1'b0;
    reg         rst_b = 1'b0;
    reg  [11:0] regAddr = 12'h000;
    reg  [7:0]  regWrData = 8'h00;
    reg         regWr = 1'b0;
    reg         regRd = 1'b0;
    wire [7:0]  regRdData;
    wire [7:1]  clkSrcIn;
    wire        sigPin;
    wire [21:1] sigSrcIn;
    wire        winPin;
    wire [23:1] winSrcIn;
    wire        clockReq;
    wire        periodMatch;
    wire        windowOpen;
    reg  [4:0]  sigCode = 5'h00;
    reg         sigLevel = 1'b0;
    reg  [4:0]  winCode = 5'h00;
    reg         winLevel = 1'b0;
    reg  [4:0]  cd;
    integer     bad_count = 0;
    integer     check_count = 0;
    integer     matchCount = 0;
    integer     m0, n, a, i, j;
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (periodMatch === 1'b1)
            matchCount <= matchCount + 1;
    signal_measure_timer_control i_dut
    (
        .core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .clkSrcIn(clkSrcIn), .sigPin(sigPin),
        .sigSrcIn(sigSrcIn), .winPin(winPin), .winSrcIn(winSrcIn),
        .clockReq(clockReq), .periodMatch(periodMatch),
        .windowOpen(windowOpen)
    );
    measure_source_model i_src
    (
        .core_clk(core_clk), .rst_b(rst_b), .sigCode(sigCode),
        .sigLevel(sigLevel), .winCode(winCode), .winLevel(winLevel),
        .clkSrcIn(clkSrcIn), .sigPin(sigPin), .sigSrcIn(sigSrcIn),
        .winPin(winPin), .winSrcIn(winSrcIn)
    );
    task test_done;
    begin
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task cyc(input integer cnt);
    begin
        regWr <= 1'b0;
        repeat (cnt) @(posedge core_clk);
    end
    endtask
    // strobe stays up until the next task drops it: no double drive
    task wr(input [11:0] ad, input [7:0] dt);
    begin
        regWr <= 1'b1;
        regAddr <= ad;
        regWrData <= dt;
        @(posedge core_clk);
    end
    endtask
    // read data stand one cycle only, so sample them mid-cycle
    task rc(input [11:0] ad, input [7:0] exp, input [7:0] mk);
    begin
        regWr <= 1'b0;
        regRd <= 1'b1;
        regAddr <= ad;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        chk(regRdData & mk, exp);
        @(posedge core_clk);
    end
    endtask
    // matches in 192 cycles with a period limit of 2
    task rate(input [2:0] cs, input [7:0] av, input integer cpm);
    begin
        wr(`MT_OFS_CTRL_A, 8'h00);
        wr(`MT_OFS_CLK_SEL, {5'h00, cs});
        wr(`MT_OFS_CTRL_A, av);
        cyc(24);
        m0 = matchCount;
        cyc(192);
        n = matchCount - m0;
        chk({7'h00, n >= 192 / cpm - 1 && n <= 192 / cpm + 1}, 8'h01);
    end
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        bad_count = bad_count + 1;
        test_done;
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        for (a = 12'h497; a <= 12'h4AF; a = a + 1)
            rc(a[11:0], (a >= 12'h4A0 && a <= 12'h4A2) ? 8'hFF : 8'h00,
               8'hFF);
        wr(`MT_OFS_CTRL_A, 8'h7F);
        rc(`MT_OFS_CTRL_A, 8'h3F, 8'hFF);
        wr(`MT_OFS_CTRL_B, 8'h35);
        rc(`MT_OFS_CTRL_B, 8'h05, 8'hFF);
        wr(`MT_OFS_CLK_SEL, 8'hFF);
        rc(`MT_OFS_CLK_SEL, 8'h07, 8'hFF);
        wr(`MT_OFS_SIG_SEL, 8'hF5);
        rc(`MT_OFS_SIG_SEL, 8'h15, 8'hFF);
        wr(`MT_OFS_WIN_SEL, 8'hF7);
        rc(`MT_OFS_WIN_SEL, 8'h17, 8'hFF);
        wr(`MT_OFS_WIN_SEL, 8'h00);
        wr(`MT_OFS_PER_L, 8'h02);
        rc(`MT_OFS_PER_L, 8'h02, 8'hFF);
        wr(`MT_OFS_PER_H, 8'h00);
        wr(`MT_OFS_PER_U, 8'h00);
        wr(`MT_OFS_CTRL_B, 8'hC0);
        rate(3'h1, 8'h80, 3);
        rate(3'h1, 8'h81, 6);
        rate(3'h1, 8'h83, 24);
        rate(3'h0, 8'h80, 12);
        rate(3'h2, 8'h80, 24);
        rate(3'h7, 8'h86, 96);
        wr(`MT_OFS_CLK_SEL, 8'h01);
        wr(`MT_OFS_CTRL_A, 8'h00);
        wr(`MT_OFS_CTRL_A, 8'hA0);
        cyc(20);
        rc(`MT_OFS_CNT_L, 8'h02, 8'hFF);
        wr(`MT_OFS_CTRL_B, 8'h40);
        cyc(4);
        wr(`MT_OFS_STATUS, 8'hC0);
        cyc(1);
        rc(`MT_OFS_STATUS, 8'h00, 8'hFF);
        rc(`MT_OFS_CPR_L, 8'h02, 8'hFF);
        rc(`MT_OFS_CPW_L, 8'h02, 8'hFF);
        wr(`MT_OFS_STATUS, 8'h10);
        cyc(1);
        rc(`MT_OFS_STATUS, 8'h00, 8'hFF);
        cyc(10);
        rc(`MT_OFS_CNT_L, 8'h00, 8'hFF);
        wr(`MT_OFS_CTRL_A, 8'h80);
        m0 = matchCount;
        wr(`MT_OFS_CTRL_B, 8'h80);
        cyc(30);
        rc(`MT_OFS_CTRL_B, 8'h00, 8'hFF);
        n = matchCount - m0;
        chk(n[7:0], 8'h01);
        chk({7'h00, clockReq}, 8'h01);
        for (a = 0; a < 11; a = a + 1)
        begin
            wr(`MT_OFS_CTRL_B, {4'hC, a[3:0]});
            rc(`MT_OFS_CTRL_B, {4'hC, a[3:0]}, 8'hFF);
            rc(`MT_OFS_STATUS, 8'h01, 8'h01);
        end
        for (a = 0; a < 2; a = a + 1)
            for (i = 0; i < 2; i = i + 1)
                for (j = 0; j < 6; j = j + 1)
                begin
                    cd = (j < 2) ? 5'h00 : (j < 4) ? 5'h01
                         : (a ? 5'h15 : 5'h17);
                    wr(`MT_OFS_CTRL_B, a ? 8'hC1 : 8'hC4);
                    wr(`MT_OFS_CTRL_A, {3'h4, a ? 1'b0 : i[0],
                       a ? i[0] : 1'b0, 3'h0});
                    winCode <= cd;
                    winLevel <= j[0];
                    sigCode <= cd;
                    sigLevel <= j[0];
                    wr(a ? `MT_OFS_SIG_SEL : `MT_OFS_WIN_SEL, {3'h0, cd});
                    cyc(10);
                    if (a == 0)
                        rc(`MT_OFS_STATUS, {6'h00, j[0] ^ i[0], 1'b0},
                           8'h02);
                    else
                        rc(`MT_OFS_STATUS, {5'h00, j[0] ^ i[0], 2'h0},
                           8'h04);
                end
        wr(`MT_OFS_CTRL_A, 8'h00);
        cyc(2);
        chk({7'h00, clockReq}, 8'h00);
        rc(`MT_OFS_CNT_L, 8'h00, 8'hFF);
        rc(`MT_OFS_STATUS, 8'h00, 8'hFF);
        test_done;
    end
endmodule
